// ===== rtc_defs.svh
// How it works
// - drive select picks open drain or push-pull
// - century bits count up at year rollover
// - century bits sit at D7 and D6
// - leap day when year divisible by four
// - century leap only when century code zero
// - irq pin follows out bit when idle
// - backup allow keeps out-low during battery
// - battery tested at power-up and daily
// - weak flag holds until a passing test
// - no battery test during battery backup
// - recovery select lives in control register
// - writes ignored during recovery deselect time
// - recovery length from select and halt bits
// - serial number is read-only
// - osc fail flag set on stop or halt
// - osc fail interrupt and its release causes
// - battery-time irq needs backup allow bit
// - first power-up defaults
// - later power-up clears enable fields
// - halt update set on fall unless tamper
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// register byte offsets
`define RTC_A_CTRL 8'h00
`define RTC_A_ENA 8'h04
`define RTC_A_FLAGS 8'h08
`define RTC_A_CAL 8'h0C
`define RTC_A_CENT 8'h10
`define RTC_A_SER_LO 8'h14
`define RTC_A_SER_HI 8'h18
`define RTC_A_STAT 8'h1C

// control register fields
`define RTC_B_OUT 7
`define RTC_B_PFDRV 6
`define RTC_B_SQDRV 5
`define RTC_B_FREE 4
`define RTC_B_RSEL 3
`define RTC_B_HALT 2
`define RTC_B_OSCIE 1
`define RTC_B_BKEN 0
// enable register fields
`define RTC_B_ALEN 0
`define RTC_B_TPEN 1
`define RTC_B_SQEN 2
`define RTC_B_FTEST 3
`define RTC_B_STAMP 4
`define RTC_F_WD 15:8
// flags register fields
`define RTC_B_HOLD 6
`define RTC_B_WEAK 4
`define RTC_B_OSCF 2
// century field and calendar fields
`define RTC_F_CENT 7:6
`define RTC_F_DATE 4:0
`define RTC_F_MONTH 11:8
`define RTC_F_YEAR 22:16

// reset values and keep masks for a later power-up
`define RTC_R_CTRL 8'hF0
`define RTC_R_ENA 16'h0000
`define RTC_R_FLAGS 8'h44
`define RTC_K_CTRL 8'hFC
`define RTC_K_ENA 16'h0010
`define RTC_LAST_YEAR 7'h63

// timing
`define RTC_CLK_KHZ 250000
`define RTC_TREC_SLOW_MS 96
`define RTC_TREC_HALT_MS 40
`define RTC_TREC_FAST_US 50
`define RTC_BATT_HOURS 24
`define RTC_OSC_HZ 32768

`endif

// ===== rtc_host_model.sv
`timescale 1ns/1ps
`include "rtc_defs.svh"
// host processor on the register bus, one whole word per transfer
module rtc_host_model (
  // clock
  input wire logic i_clock,
  // slave answer
  input wire rtc_pkg::rtc_ahb_rsp_t i_ahb,
  // master request
  output rtc_pkg::rtc_ahb_req_t o_ahb
);
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;

  // single slave, so its ready is the bus ready
  assign o_ahb = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, i_ahb.hreadyout};

  // address phase held until ready, then data phase held until ready
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge i_clock); while (i_ahb.hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge i_clock); while (i_ahb.hreadyout !== 1'b1);
    q = i_ahb.hrdata;
    // released data lines change, so a stale word is never mistaken
    hwdata <= ~hwdata;
  endtask : xfer

  // clear by zero
  // only a zero clears the fail flag; called once the oscillator runs
  task automatic clear_flags();
    logic [31:0] q;
    xfer(1'b1, {24'h0, `RTC_A_FLAGS}, 32'h0, q);
  endtask : clear_flags
endmodule : rtc_host_model

// ===== rtc_pkg.sv
package rtc_pkg;

  // power state of the supervisor
  typedef enum logic [1:0] {
    RTC_BATTERY,
    RTC_RECOVER,
    RTC_ON
  } rtc_pwr_t;

  // ahb-lite request from the master
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } rtc_ahb_req_t;

  // ahb-lite answer of the slave
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } rtc_ahb_rsp_t;

endpackage : rtc_pkg

// ===== rtc_status_and_supervisor_bits_tb_top.sv
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_status_and_supervisor_bits_tb_top;
  // arbitrary serial value for this bench
  localparam logic [63:0] SERIAL = 64'hC3A51E7B9D246F08;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] pfi;
    logic [7:0] cent;
    logic [31:0] cal;
    logic [1:0] e_out;
    logic [1:0] e_oe;
    logic e_irq;
    logic [31:0] e_cal;
    logic [7:0] e_cent;
  } rtc_row_t;
  // control, pins, century and a date that the day pulse advances
  rtc_row_t rows [8] = '{
    '{8'h80, 2'h1, 8'h40, 32'h00630C1F, 2'h1, 2'h3, 1'b0, 32'h101, 8'h80},
    '{8'h80, 2'h2, 8'h40, 32'h0000021C, 2'h2, 2'h3, 1'b0, 32'h301, 8'h40},
    '{8'hC0, 2'h1, 8'h00, 32'h0000021C, 2'h0, 2'h2, 1'b0, 32'h21D, 8'h00},
    '{8'h40, 2'h0, 8'h80, 32'h0000021C, 2'h0, 2'h3, 1'b1, 32'h301, 8'h80},
    '{8'h00, 2'h3, 8'hC0, 32'h0000021C, 2'h3, 2'h3, 1'b1, 32'h301, 8'hC0},
    '{8'h82, 2'h3, 8'h00, 32'h0004021C, 2'h3, 2'h3, 1'b1, 32'h4021D, 8'h00},
    '{8'h80, 2'h3, 8'h00, 32'h0001021C, 2'h3, 2'h3, 1'b0, 32'h10301, 8'h00},
    '{8'hC0, 2'h3, 8'hC0, 32'h00630C1F, 2'h0, 2'h0, 1'b0, 32'h101, 8'h00}
  };
  localparam logic [7:0] RC [4] = '{8'h80, 8'h84, 8'h88, 8'h8C};
  localparam int RT [4] = '{20, 30, 10, 10};
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_vcc_ok = 1'b0;
  logic i_battery_low = 1'b0;
  logic i_osc_stopped = 1'b0;
  logic i_osc_clk = 1'b0;
  logic [1:0] i_pfi_ok = 2'h0;
  logic i_day_tick = 1'b0;
  rtc_pkg::rtc_ahb_req_t ahb_req;
  rtc_pkg::rtc_ahb_rsp_t ahb_rsp;
  logic [1:0] pf_pin, pf_oe, century;
  logic irq_oe, fr_oe, rst_n, irq_out, fr_out, desel;
  logic [1:0] osc_div = 2'h0;
  logic [31:0] q;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int fr_cnt = 0;
  int n, k;

  // clock generator
  initial forever #2 i_clock = ~i_clock;

  // slow oscillator, period of eight clocks, plus free-run low counter
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3)
      i_osc_clk <= ~i_osc_clk;
    if (fr_oe === 1'b1)
      fr_cnt <= fr_cnt + 1;
  end

  rtc_host_model host (
    .i_clock(i_clock),
    .i_ahb(ahb_rsp),
    .o_ahb(ahb_req)
  );

  rtc_supervisor #(
    .P_REC_SLOW(32'd20),
    .P_REC_HALT(32'd30),
    .P_REC_FAST(32'd10),
    .P_BATT_TICKS(32'd16),
    .P_SERIAL(SERIAL)
  ) DUT (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_ahb(ahb_req),
    .o_ahb(ahb_rsp),
    .i_vcc_ok(i_vcc_ok),
    .i_battery_low(i_battery_low),
    .i_osc_stopped(i_osc_stopped),
    .i_osc_clk(i_osc_clk),
    .i_pfi_ok(i_pfi_ok),
    .i_day_tick(i_day_tick),
    .o_power_fail_output_n(pf_pin),
    .o_power_fail_oe(pf_oe),
    .o_irq_out(irq_out),
    .o_irq_oe(irq_oe),
    .o_free_run_out(fr_out),
    .o_free_run_oe(fr_oe),
    .o_reset_n(rst_n),
    .o_deselected(desel),
    .o_century(century)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, {24'h0, a}, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, {24'h0, a}, 32'h0, q);
    check(q, e);
  endtask : rd

  // move the supply; on the rise a write is tried while deselected
  task automatic supply(input logic v, output int t);
    int t0;
    t0 = cyc;
    i_vcc_ok <= v;
    if (v) begin
      // land the write inside the recovery window, not before it
      repeat (6) @(posedge i_clock);
      wr(`RTC_A_CENT, 32'hC0);
    end
    while (rst_n !== v && cyc - t0 < 300)
      @(posedge i_clock);
    t = cyc - t0;
    // a supply step that never settles counts as a mismatch
    check(32'(rst_n), 32'(v));
  endtask : supply

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // a hang is cut well beyond the thousand or so cycles the run needs
  initial begin
    #200000;
    fails++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clock);
    supply(1'b1, n);
    rd(`RTC_A_CENT, 32'h0);
    foreach (rows[i]) begin
      wr(`RTC_A_CTRL, {24'h0, rows[i].ctrl});
      wr(`RTC_A_CENT, {24'h0, rows[i].cent});
      wr(`RTC_A_CAL, rows[i].cal);
      i_pfi_ok <= rows[i].pfi;
      i_day_tick <= 1'b1;
      @(posedge i_clock);
      i_day_tick <= 1'b0;
      repeat (8) @(posedge i_clock);
      check(32'(pf_pin), 32'(rows[i].e_out));
      check(32'(pf_oe), 32'(rows[i].e_oe));
      check(32'(irq_oe), 32'(rows[i].e_irq));
      rd(`RTC_A_CAL, rows[i].e_cal);
      rd(`RTC_A_CENT, {24'h0, rows[i].e_cent});
      check(32'(century), 32'(rows[i].e_cent[7:6]));
      check(32'(desel), 32'h0);
      check(32'({irq_out, fr_out}), 32'h0);
    end
    // second reset while on battery gives the first power-up values
    supply(1'b0, n);
    i_rstn <= 1'b0;
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clock);
    rd(`RTC_A_CTRL, 32'hF0);
    rd(`RTC_A_ENA, 32'h0);
    rd(`RTC_A_FLAGS, 32'h44);
    rd(`RTC_A_CAL, 32'h101);
    supply(1'b1, n);
    rd(`RTC_A_SER_LO, SERIAL[31:0]);
    wr(`RTC_A_SER_LO, ~SERIAL[31:0]);
    rd(`RTC_A_SER_LO, SERIAL[31:0]);
    rd(`RTC_A_SER_HI, SERIAL[63:32]);
    host.clear_flags();
    rd(`RTC_A_FLAGS, 32'h0);
    wr(`RTC_A_CTRL, 32'h84);
    rd(`RTC_A_FLAGS, 32'h04);
    // deselect length for each select and halt setting
    foreach (RC[i]) begin
      wr(`RTC_A_CTRL, {24'h0, RC[i]});
      supply(1'b0, n);
      supply(1'b1, n);
      check(32'(n >= RT[i] && n <= RT[i] + 8), 32'h1);
      rd(`RTC_A_CENT, 32'h0);
      rd(`RTC_A_CTRL, {24'h0, RC[i]});
    end
    // later power-up clears the enables; tamper stamp blocks the halt flag
    wr(`RTC_A_CTRL, 32'h83);
    host.clear_flags();
    wr(`RTC_A_ENA, 32'hAB1F);
    supply(1'b0, n);
    supply(1'b1, n);
    rd(`RTC_A_CTRL, 32'h80);
    rd(`RTC_A_ENA, 32'h10);
    rd(`RTC_A_FLAGS, 32'h0);
    wr(`RTC_A_ENA, 32'h0);
    supply(1'b0, n);
    supply(1'b1, n);
    rd(`RTC_A_FLAGS, 32'h40);
    // a stopped oscillator raises the flag and the enabled interrupt
    wr(`RTC_A_CTRL, 32'h82);
    i_osc_stopped <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_osc_stopped <= 1'b0;
    repeat (8) @(posedge i_clock);
    rd(`RTC_A_FLAGS, 32'h44);
    check(32'(irq_oe), 32'h1);
    host.clear_flags();
    repeat (2) @(posedge i_clock);
    check(32'(irq_oe), 32'h0);
    // battery time: level output needs the allow bit, no battery test
    wr(`RTC_A_CTRL, 32'h01);
    supply(1'b0, n);
    repeat (8) @(posedge i_clock);
    check(32'(irq_oe), 32'h1);
    supply(1'b1, n);
    wr(`RTC_A_CTRL, 32'h10);
    i_battery_low <= 1'b1;
    supply(1'b0, n);
    k = fr_cnt;
    repeat (200) @(posedge i_clock);
    check(32'(irq_oe), 32'h0);
    check(32'(desel), 32'h1);
    check(32'(fr_cnt - k), 32'h0);
    rd(`RTC_A_FLAGS, 32'h40);
    supply(1'b1, n);
    i_battery_low <= 1'b0;
    repeat (40) @(posedge i_clock);
    rd(`RTC_A_FLAGS, 32'h50);
    k = fr_cnt;
    repeat (150) @(posedge i_clock);
    rd(`RTC_A_FLAGS, 32'h40);
    check(32'(fr_cnt - k > 40), 32'h1);
    finish_test();
  end
endmodule : rtc_status_and_supervisor_bits_tb_top

// ===== rtc_supervisor.sv
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_supervisor #(
  parameter logic [31:0] P_REC_SLOW = 32'(`RTC_TREC_SLOW_MS * `RTC_CLK_KHZ),
  parameter logic [31:0] P_REC_HALT = 32'(`RTC_TREC_HALT_MS * `RTC_CLK_KHZ),
  parameter logic [31:0] P_REC_FAST =
    32'((`RTC_TREC_FAST_US * `RTC_CLK_KHZ + 999) / 1000),
  parameter logic [31:0] P_BATT_TICKS =
    32'(64'(`RTC_BATT_HOURS) * 64'd3600 * 64'(`RTC_OSC_HZ)),
  // arbitrary value, one per part in production
  parameter logic [63:0] P_SERIAL = 64'h5A3C_96E1_0F2D_B487
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // register bus
  input wire rtc_pkg::rtc_ahb_req_t i_ahb,
  output rtc_pkg::rtc_ahb_rsp_t o_ahb,
  // asynchronous monitor inputs
  input wire logic i_vcc_ok,
  input wire logic i_battery_low,
  input wire logic i_osc_stopped,
  input wire logic i_osc_clk,
  input wire logic [1:0] i_pfi_ok,
  // timekeeping day pulse, same clock
  input wire logic i_day_tick,
  // power-fail pins
  output logic [1:0] o_power_fail_output_n,
  output logic [1:0] o_power_fail_oe,
  // interrupt / output driver pin, open drain
  output logic o_irq_out,
  output logic o_irq_oe,
  // free-running clock pin, open drain
  output logic o_free_run_out,
  output logic o_free_run_oe,
  // supervisor state
  output logic o_reset_n,
  output logic o_deselected,
  output logic [1:0] o_century
);

  localparam int S_VCC = 0;
  localparam int S_BAT = 1;
  localparam int S_STOP = 2;
  localparam int S_OSC = 3;
  localparam int S_PFI = 4;

  // reset release through two flops
  logic [1:0] rst_q;
  logic rst_n;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // three-flop synchronisers; a change counts once stages two and three agree
  logic [5:0] pin_in;
  logic [5:0] sy1;
  logic [5:0] sy2;
  logic [5:0] sy3;
  logic [5:0] filt;
  logic [5:0] next_filt;
  assign pin_in = {i_pfi_ok, i_osc_clk, i_osc_stopped, i_battery_low,
                   i_vcc_ok};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_comb begin
        next_filt[gi] = (sy2[gi] == sy3[gi]) ? sy3[gi] : filt[gi];
      end
      always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
          sy1[gi] <= 1'b0;
          sy2[gi] <= 1'b0;
          sy3[gi] <= 1'b0;
          filt[gi] <= 1'b0;
        end else begin
          sy1[gi] <= pin_in[gi];
          sy2[gi] <= sy1[gi];
          sy3[gi] <= sy2[gi];
          filt[gi] <= next_filt[gi];
        end
      end
    end
  endgenerate

  // register and supervisor state
  logic [7:0] ctrl, next_ctrl;
  logic [15:0] ena, next_ena;
  logic [7:0] flags, next_flags;
  logic [4:0] date, next_date;
  logic [3:0] month, next_month;
  logic [6:0] year, next_year;
  logic [1:0] cent, next_cent;
  rtc_pkg::rtc_pwr_t pwr, next_pwr;
  logic [31:0] rec_cnt, next_rec_cnt;
  logic [31:0] batt_cnt, next_batt_cnt;
  logic [1:0] pf_lvl, next_pf_lvl;
  logic vcc_d, osc_d;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] rdata, next_rdata;

  logic vcc_rise, vcc_fall, osc_tick, acc, wr_ok, cal_wr, leap, irq_mode;
  logic [31:0] wdat, rd_mux;
  logic [4:0] mdays;

  assign vcc_rise = filt[S_VCC] & ~vcc_d;
  assign vcc_fall = ~filt[S_VCC] & vcc_d;
  assign osc_tick = filt[S_OSC] & ~osc_d;
  assign acc = i_ahb.hsel & i_ahb.htrans[1] & i_ahb.hready;
  assign wdat = i_ahb.hwdata;
  assign wr_ok = wr_pend & (pwr == rtc_pkg::RTC_ON);
  assign cal_wr = wr_ok & ((wr_addr == `RTC_A_CAL) |
                           (wr_addr == `RTC_A_CENT));
  // leap on years divisible by four
  // century years only with code zero
  assign leap = (year[1:0] == 2'h0) & ((year != 7'h00) | (cent == 2'h0));

  // days in the current month
  always_comb begin
    case (month)
      4'h2: mdays = leap ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: mdays = 5'h1E;
      default: mdays = 5'h1F;
    endcase
  end

  // read multiplexer, unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0;
    case (i_ahb.haddr[7:0])
      `RTC_A_CTRL: rd_mux[7:0] = ctrl;
      `RTC_A_ENA: rd_mux[15:0] = ena;
      `RTC_A_FLAGS: rd_mux[7:0] = flags;
      `RTC_A_CAL: begin
        rd_mux[`RTC_F_DATE] = date;
        rd_mux[`RTC_F_MONTH] = month;
        rd_mux[`RTC_F_YEAR] = year;
      end
      `RTC_A_CENT: rd_mux[`RTC_F_CENT] = cent;
      `RTC_A_SER_LO: rd_mux = P_SERIAL[31:0];
      `RTC_A_SER_HI: rd_mux = P_SERIAL[63:32];
      `RTC_A_STAT: rd_mux[2:0] = {pwr == rtc_pkg::RTC_ON,
                                  pwr == rtc_pkg::RTC_RECOVER, filt[S_VCC]};
      default: rd_mux = 32'h0;
    endcase
  end

  // next state of bus, registers, calendar and power supervisor
  always_comb begin
    next_ctrl = ctrl;
    next_ena = ena;
    next_flags = flags;
    next_date = date;
    next_month = month;
    next_year = year;
    next_cent = cent;
    next_pwr = pwr;
    next_rec_cnt = rec_cnt;
    next_batt_cnt = batt_cnt;
    next_pf_lvl = pf_lvl;
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_rdata = rdata;
    // address phase: reads sampled now, writes land in the data phase
    if (acc) begin
      next_wr_pend = i_ahb.hwrite;
      next_wr_addr = i_ahb.haddr[7:0];
      if (!i_ahb.hwrite) begin
        next_rdata = rd_mux;
      end
    end
    if (wr_ok) begin
      case (wr_addr)
        // recovery select is a control bit
        `RTC_A_CTRL: next_ctrl = wdat[7:0];
        `RTC_A_ENA: next_ena = wdat[15:0];
        `RTC_A_FLAGS: begin
          next_flags[`RTC_B_HOLD] = wdat[`RTC_B_HOLD];
          if (!wdat[`RTC_B_OSCF]) begin
            next_flags[`RTC_B_OSCF] = 1'b0;
          end
        end
        `RTC_A_CAL: begin
          next_date = wdat[`RTC_F_DATE];
          next_month = wdat[`RTC_F_MONTH];
          next_year = wdat[`RTC_F_YEAR];
        end
        `RTC_A_CENT: next_cent = wdat[`RTC_F_CENT];
        default: ;
      endcase
    end
    // calendar; a host write wins over the day pulse in the same cycle
    if (i_day_tick && !cal_wr) begin
      if (date < mdays) begin
        next_date = date + 5'h01;
      end else begin
        next_date = 5'h01;
        if (month < 4'hC) begin
          next_month = month + 4'h1;
        end else begin
          next_month = 4'h1;
          if (year < `RTC_LAST_YEAR) begin
            next_year = year + 7'h01;
          end else begin
            next_year = 7'h00;
            next_cent = cent + 2'h1;
          end
        end
      end
    end
    // stop or halt sets the flag, set beats clear
    if (filt[S_STOP] ||
        (wr_ok && wr_addr == `RTC_A_CTRL && wdat[`RTC_B_HALT])) begin
      next_flags[`RTC_B_OSCF] = 1'b1;
    end
    // power sequencing
    case (pwr)
      rtc_pkg::RTC_BATTERY: begin
        next_pf_lvl = 2'h0;
        if (vcc_rise) begin
          next_pwr = rtc_pkg::RTC_RECOVER;
          next_pf_lvl = 2'h3;
          if (ctrl[`RTC_B_RSEL]) begin
            next_rec_cnt = P_REC_FAST;
          end else if (ctrl[`RTC_B_HALT]) begin
            next_rec_cnt = P_REC_HALT;
          end else begin
            next_rec_cnt = P_REC_SLOW;
          end
        end
      end
      rtc_pkg::RTC_RECOVER: begin
        next_pf_lvl = 2'h3;
        if (!filt[S_VCC]) begin
          next_pwr = rtc_pkg::RTC_BATTERY;
          next_pf_lvl = 2'h0;
        end else if (rec_cnt <= 32'h1) begin
          next_pwr = rtc_pkg::RTC_ON;
        end else begin
          next_rec_cnt = rec_cnt - 32'h1;
        end
      end
      rtc_pkg::RTC_ON: begin
        next_pf_lvl = filt[S_PFI +: 2];
        if (!filt[S_VCC]) begin
          next_pwr = rtc_pkg::RTC_BATTERY;
          next_pf_lvl = 2'h0;
        end
      end
      default: next_pwr = rtc_pkg::RTC_BATTERY;
    endcase
    // test at power-up; restart the daily count
    if (vcc_rise) begin
      next_flags[`RTC_B_WEAK] = filt[S_BAT];
      next_batt_cnt = 32'h0;
      next_ctrl = next_ctrl & `RTC_K_CTRL;
      next_ena = next_ena & `RTC_K_ENA;
    // count and test only on main supply
    end else if (filt[S_VCC] && pwr != rtc_pkg::RTC_BATTERY && osc_tick) begin
      if (batt_cnt >= P_BATT_TICKS - 32'h1) begin
        next_batt_cnt = 32'h0;
        // flag follows each later test result
        next_flags[`RTC_B_WEAK] = filt[S_BAT];
      end else begin
        next_batt_cnt = batt_cnt + 32'h1;
      end
    end
    // power-down sets halt update unless tamper stamps
    if (vcc_fall && !ena[`RTC_B_STAMP]) begin
      next_flags[`RTC_B_HOLD] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `RTC_R_CTRL;
      ena <= `RTC_R_ENA;
      flags <= `RTC_R_FLAGS;
      date <= 5'h01;
      month <= 4'h1;
      year <= 7'h00;
      cent <= 2'h0;
      pwr <= rtc_pkg::RTC_BATTERY;
      rec_cnt <= 32'h0;
      batt_cnt <= 32'h0;
      pf_lvl <= 2'h0;
      vcc_d <= 1'b0;
      osc_d <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      ena <= next_ena;
      flags <= next_flags;
      date <= next_date;
      month <= next_month;
      year <= next_year;
      cent <= next_cent;
      pwr <= next_pwr;
      rec_cnt <= next_rec_cnt;
      batt_cnt <= next_batt_cnt;
      pf_lvl <= next_pf_lvl;
      vcc_d <= filt[S_VCC];
      osc_d <= filt[S_OSC];
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      rdata <= next_rdata;
    end
  end

  // bus answer: zero wait states, always okay
  assign o_ahb.hrdata = rdata;
  assign o_ahb.hreadyout = 1'b1;
  assign o_ahb.hresp = 1'b0;

  // open drain only pulls low, push-pull always drives
  assign o_power_fail_output_n = ctrl[`RTC_B_PFDRV] ? 2'h0 : pf_lvl;
  assign o_power_fail_oe = ctrl[`RTC_B_PFDRV] ? ~pf_lvl : 2'h3;

  // irq pin; in interrupt mode recovery counts as reset asserted and releases it
  assign irq_mode = ena[`RTC_B_TPEN] | ctrl[`RTC_B_OSCIE] | ena[`RTC_B_ALEN] |
                    (ena[`RTC_F_WD] != 8'h00);
  assign o_irq_out = 1'b0;
  always_comb begin
    o_irq_oe = 1'b0;
    if (irq_mode) begin
      // osc fail interrupt, battery needs allow bit
      if (pwr == rtc_pkg::RTC_ON) begin
        o_irq_oe = flags[`RTC_B_OSCF] & ctrl[`RTC_B_OSCIE];
      end else if (pwr == rtc_pkg::RTC_BATTERY) begin
        o_irq_oe = flags[`RTC_B_OSCF] & ctrl[`RTC_B_OSCIE] & ctrl[`RTC_B_BKEN];
      end
    end else begin
      // out bit drives; kept in battery when allowed
      o_irq_oe = ~ctrl[`RTC_B_OUT] &
                 ((pwr != rtc_pkg::RTC_BATTERY) | ctrl[`RTC_B_BKEN]);
    end
  end

  // free-run clock stops in battery backup or when halted
  assign o_free_run_out = 1'b0;
  assign o_free_run_oe = ctrl[`RTC_B_FREE] & ~ctrl[`RTC_B_HALT] &
                         (pwr != rtc_pkg::RTC_BATTERY) & ~osc_d;
  assign o_reset_n = (pwr == rtc_pkg::RTC_ON);
  assign o_deselected = (pwr != rtc_pkg::RTC_ON);
  assign o_century = cent;

  property p_pf_push;
    @(posedge i_clock) disable iff (!rst_n)
      !ctrl[`RTC_B_PFDRV] |-> (o_power_fail_oe == 2'h3) &&
        (o_power_fail_output_n == pf_lvl);
  endproperty
  a_pf_push: assert property (p_pf_push)
    else $error("push-pull power-fail output not driven");

  property p_cent;
    @(posedge i_clock) disable iff (!rst_n)
      i_day_tick && !cal_wr && year == `RTC_LAST_YEAR && month == 4'hC &&
      date == 5'h1F |=> cent == $past(cent) + 2'h1 && year == 7'h00;
  endproperty
  a_cent: assert property (p_cent)
    else $error("century did not advance at year rollover");

  property p_leap;
    @(posedge i_clock) disable iff (!rst_n)
      i_day_tick && !cal_wr && month == 4'h2 && date == 5'h1C |=>
        (date == 5'h1D) == $past(year[1:0] == 2'h0 &&
                                 (year != 7'h00 || cent == 2'h0));
  endproperty
  a_leap: assert property (p_leap)
    else $error("leap day decision wrong");

  property p_out_pin;
    @(posedge i_clock) disable iff (!rst_n)
      !irq_mode && pwr == rtc_pkg::RTC_ON |-> o_irq_oe == !ctrl[`RTC_B_OUT];
  endproperty
  a_out_pin: assert property (p_out_pin)
    else $error("irq pin does not follow out bit");

  property p_batt_test;
    @(posedge i_clock) disable iff (!rst_n)
      vcc_rise |=> flags[`RTC_B_WEAK] == $past(filt[S_BAT]) && batt_cnt == 0;
  endproperty
  a_batt_test: assert property (p_batt_test)
    else $error("battery not tested at power-up");

  property p_no_test;
    @(posedge i_clock) disable iff (!rst_n)
      pwr == rtc_pkg::RTC_BATTERY && !vcc_rise |=> $stable(batt_cnt) &&
        $stable(flags[`RTC_B_WEAK]);
  endproperty
  a_no_test: assert property (p_no_test)
    else $error("battery test ran in backup");

  property p_desel;
    @(posedge i_clock) disable iff (!rst_n)
      wr_pend && pwr != rtc_pkg::RTC_ON && wr_addr == `RTC_A_CENT &&
      !i_day_tick |=> cent == $past(cent);
  endproperty
  a_desel: assert property (p_desel)
    else $error("write taken while deselected");

  property p_rec_len;
    @(posedge i_clock) disable iff (!rst_n)
      pwr == rtc_pkg::RTC_BATTERY && vcc_rise && ctrl[`RTC_B_RSEL] |=>
        rec_cnt == P_REC_FAST;
  endproperty
  a_rec_len: assert property (p_rec_len)
    else $error("fast recovery length not loaded");

  property p_of_set;
    @(posedge i_clock) disable iff (!rst_n)
      filt[S_STOP] |=> flags[`RTC_B_OSCF] [*2];
  endproperty
  a_of_set: assert property (p_of_set)
    else $error("oscillator stop did not set fail flag");

  property p_ht;
    @(posedge i_clock) disable iff (!rst_n)
      vcc_fall && !ena[`RTC_B_STAMP] |=> flags[`RTC_B_HOLD];
  endproperty
  a_ht: assert property (p_ht)
    else $error("halt update not set on power-down");

endmodule : rtc_supervisor
